// >>> hw/sps_defines.vh
// register map, field positions and reset values of the shared i/o port
// assumes wishbone byte addresses are four times the register index
`ifndef SPS_DEFINES_VH
`define SPS_DEFINES_VH

// register indices; byte address is four times the index
`define SPS_PB_DIR_IDX      16'hFFD4
`define SPS_PB_DATA_IDX     16'hFFD6
`define SPS_PA_DIR_IDX      16'hFFD1
`define SPS_PA_DATA_IDX     16'hFFD3
`define SPS_NDE_LO_IDX      16'hFFE0
`define SPS_NDE_HI_IDX      16'hFFE1

// reset values
`define SPS_PB_DIR_RST      8'h00
`define SPS_PB_DATA_RST     8'h00
`define SPS_PA_DIR_RST      3'h0
`define SPS_PA_DATA_RST     3'h0
`define SPS_NDE_LO_RST      3'h0
`define SPS_NDE_HI_RST      8'h00

// read value of the write-only direction register
`define SPS_PB_DIR_READ     8'hFF

// prescaler select codes
`define SPS_PSC_CLK_C       3'h6
`define SPS_PSC_CLK_B       3'h5

// timer channel 0 a-side io control field
`define SPS_IOA_MSB         2
`define SPS_IOA_NONE        2'h0

// port a pin positions
`define SPS_PIN_A2          2
`define SPS_PIN_A1          1
`define SPS_PIN_A0          0

// wishbone
`define SPS_ADR_W           18
`define SPS_DAT_W           32
`define SPS_BYTE_W          8

`endif

// >>> hw/sps_port.v
// shared i/o port: pin selection for port a pins 2..0 and port b registers
// assumes a classic wishbone master and timer/pattern units outside
// Contract
// - Ch0 pwm or compare-output code: a2 drives timer output.
// - Else a2 input at dir 0, else port data or pattern bit 2.
// - A2 feeds ch0 capture whenever io control msb is 1.
// - A2 is external clock c when any prescaler select is 110.
// - A1, a0 input at dir 0, else port data or pattern bit.
// - A1 is external clock b on phase counting or select 101.
// - A0 is external clock a on phase counting or select 10x.
// - Port b: eight bidirectional pins, same functions in every mode.
// - Port b pin outputs at direction bit 1, else input.
// - Port b direction is write-only and reads all ones.
// - Port b direction clears on reset, hw standby; kept in sw standby.
// - In sw standby port b output pins keep driving.
// - Port b read: data bit for outputs, pin level for inputs.
// - Port b data clears on reset, hw standby; kept in sw standby.
// - Port b data register holds pattern output groups 2 and 3.
// - Locked data bits ignore cpu writes; only transfers, reset and hw standby change them.
`include "sps_defines.vh"

module sps_port (
    input  wire                    clk_i,
    input  wire                    rst_i,
    // wishbone classic slave
    input  wire                    wb_cyc_i,
    input  wire                    wb_stb_i,
    input  wire                    wb_we_i,
    input  wire [`SPS_ADR_W-1:0]   wb_adr_i,
    input  wire [3:0]              wb_sel_i,
    input  wire [`SPS_DAT_W-1:0]   wb_dat_i,
    output reg  [`SPS_DAT_W-1:0]   wb_dat_o,
    output reg                     wb_ack_o,
    // standby
    input  wire                    hw_standby_i,
    input  wire                    sw_standby_i,
    // timer settings
    input  wire                    ch0_pwm_mode_i,
    input  wire [2:0]              timer_ch0_io_control_i,
    input  wire [14:0]             prescale_sel_i,
    input  wire                    phase_count_mode_i,
    input  wire                    timer_ch0_a_out_i,
    // pattern unit
    input  wire [2:0]              pattern_out_i,
    input  wire [7:0]              upper_next_data_i,
    input  wire                    upper_transfer_i,
    // port a pins 2..0
    input  wire [2:0]              pa_pin_i,
    output reg  [2:0]              pa_pin_o,
    output reg  [2:0]              pa_pin_oe_o,
    // timer inputs taken from port a
    output reg                     timer_ch0_a_pin_o,
    output reg                     ext_timer_clock_a_o,
    output reg                     ext_timer_clock_b_o,
    output reg                     ext_timer_clock_c_o,
    // port b pins
    input  wire [7:0]              pb_pin_i,
    output reg  [7:0]              pb_pin_o,
    output reg  [7:0]              pb_pin_oe_o
);

    reg  [7:0]  pb_dir_q;
    reg  [7:0]  pb_dir_d;
    reg  [7:0]  pb_data_q;
    reg  [7:0]  pb_data_d;
    reg  [2:0]  pa_dir_q;
    reg  [2:0]  pa_data_q;
    reg  [2:0]  nde_lo_q;
    reg  [7:0]  nde_hi_q;

    wire [15:0] word_idx;
    wire        req;
    wire        wr_lane;
    wire [7:0]  wbyte;
    wire        hit_pb_dir;
    wire        hit_pb_data;
    wire        hit_pa_dir;
    wire        hit_pa_data;
    wire        hit_nde_lo;
    wire        hit_nde_hi;

    reg         any_clk_c;
    reg         any_clk_b;
    reg         any_clk_a;
    wire [4:0]  sel_clk_c;
    wire [4:0]  sel_clk_b;
    wire [4:0]  sel_clk_a;
    wire [2:0]  pa_oe_gen;
    wire [2:0]  pa_out_gen;
    genvar      g;

    reg         a2_timer_own;
    reg  [2:0]  pa_out_d;
    reg  [2:0]  pa_oe_d;
    reg  [7:0]  rd_byte;

    assign word_idx = wb_adr_i[`SPS_ADR_W-1:2];
    assign req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // write lands at the edge where the master sees ack
    assign wr_lane  = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
    assign wbyte    = wb_dat_i[`SPS_BYTE_W-1:0];

    // register selects
    assign hit_pb_dir  = (word_idx == `SPS_PB_DIR_IDX);
    assign hit_pb_data = (word_idx == `SPS_PB_DATA_IDX);
    assign hit_pa_dir  = (word_idx == `SPS_PA_DIR_IDX);
    assign hit_pa_data = (word_idx == `SPS_PA_DATA_IDX);
    assign hit_nde_lo  = (word_idx == `SPS_NDE_LO_IDX);
    assign hit_nde_hi  = (word_idx == `SPS_NDE_HI_IDX);

    // prescaler decode over timer control 4..0
    generate
        for (g = 0; g < 5; g = g + 1) begin : g_psc
            sps_psc_dec u_psc (
                .psc_i   (prescale_sel_i[3*g +: 3]),
                .clk_c_o (sel_clk_c[g]),
                .clk_b_o (sel_clk_b[g]),
                .clk_a_o (sel_clk_a[g])
            );
        end
    endgenerate

    // any of the five controls claims the pin as clock
    always @* begin
        any_clk_c = |sel_clk_c;
        any_clk_b = |sel_clk_b;
        any_clk_a = |sel_clk_a;
    end

    // port a data or pattern per pin
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_pa
            sps_pa_mux u_pa (
                .dir_i     (pa_dir_q[g]),
                .nde_i     (nde_lo_q[g]),
                .data_i    (pa_data_q[g]),
                .pattern_i (pattern_out_i[g]),
                .oe_o      (pa_oe_gen[g]),
                .out_o     (pa_out_gen[g])
            );
        end
    endgenerate

    // port a pin function selection
    always @* begin
        a2_timer_own = ch0_pwm_mode_i |
            (~timer_ch0_io_control_i[`SPS_IOA_MSB] &
             (timer_ch0_io_control_i[1:0] != `SPS_IOA_NONE));
        pa_oe_d  = pa_oe_gen;
        pa_out_d = pa_out_gen;
        if (a2_timer_own) begin
            pa_oe_d[`SPS_PIN_A2]  = 1'b1;
            pa_out_d[`SPS_PIN_A2] = timer_ch0_a_out_i;
        end
    end

    // port b next values
    always @* begin
        pb_dir_d  = pb_dir_q;
        pb_data_d = pb_data_q;
        if (wr_lane && hit_pb_dir) begin
            pb_dir_d = wbyte;
        end
        // locked bits keep cpu writes out
        if (wr_lane && hit_pb_data) begin
            pb_data_d = (pb_data_q & nde_hi_q) | (wbyte & ~nde_hi_q);
        end
        if (upper_transfer_i) begin
            pb_data_d = (pb_data_d & ~nde_hi_q) |
                        (upper_next_data_i & nde_hi_q);
        end
    end

    // read multiplexer
    always @* begin
        case (word_idx)
            `SPS_PB_DIR_IDX:  rd_byte = `SPS_PB_DIR_READ;
            `SPS_PB_DATA_IDX: rd_byte = (pb_data_q & pb_dir_q) |
                                        (pb_pin_i & ~pb_dir_q);
            `SPS_PA_DIR_IDX:  rd_byte = {5'h00, pa_dir_q};
            `SPS_PA_DATA_IDX: rd_byte = {5'h00, (pa_data_q & pa_dir_q) |
                                                (pa_pin_i & ~pa_dir_q)};
            `SPS_NDE_LO_IDX:  rd_byte = {5'h00, nde_lo_q};
            `SPS_NDE_HI_IDX:  rd_byte = nde_hi_q;
            default:          rd_byte = 8'h00;
        endcase
    end

    // wishbone answer, one wait state
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            if (req && !wb_we_i) begin
                wb_dat_o <= {24'h000000, rd_byte};
            end
        end
    end

    // port b registers
    always @(posedge clk_i) begin
        // clear on reset and hw standby
        if (rst_i || hw_standby_i) begin
            pb_dir_q  <= `SPS_PB_DIR_RST;
            pb_data_q <= `SPS_PB_DATA_RST;
        end else begin
            // data register also carries pattern groups
            pb_dir_q  <= pb_dir_d;
            pb_data_q <= pb_data_d;
        end
    end

    // port b pins; sw standby leaves state as is
    always @(posedge clk_i) begin
        if (rst_i || hw_standby_i) begin
            pb_pin_o    <= 8'h00;
            pb_pin_oe_o <= 8'h00;
        end else begin
            pb_pin_o    <= pb_data_d;
            pb_pin_oe_o <= pb_dir_d;
        end
    end

    // own control registers for port a and enables
    always @(posedge clk_i) begin
        if (rst_i) begin
            pa_dir_q  <= `SPS_PA_DIR_RST;
            pa_data_q <= `SPS_PA_DATA_RST;
            nde_lo_q  <= `SPS_NDE_LO_RST;
            nde_hi_q  <= `SPS_NDE_HI_RST;
        end else begin
            if (wr_lane && hit_pa_dir) begin
                pa_dir_q <= wbyte[2:0];
            end
            if (wr_lane && hit_pa_data) begin
                pa_data_q <= wbyte[2:0];
            end
            if (wr_lane && hit_nde_lo) begin
                nde_lo_q <= wbyte[2:0];
            end
            if (wr_lane && hit_nde_hi) begin
                nde_hi_q <= wbyte;
            end
        end
    end

    // port a pins and timer inputs
    always @(posedge clk_i) begin
        if (rst_i) begin
            pa_pin_o            <= 3'h0;
            pa_pin_oe_o         <= 3'h0;
            timer_ch0_a_pin_o   <= 1'b0;
            ext_timer_clock_a_o <= 1'b0;
            ext_timer_clock_b_o <= 1'b0;
            ext_timer_clock_c_o <= 1'b0;
        end else begin
            pa_pin_o    <= pa_out_d;
            pa_pin_oe_o <= pa_oe_d;
            timer_ch0_a_pin_o <= timer_ch0_io_control_i[`SPS_IOA_MSB] &
                                 pa_pin_i[`SPS_PIN_A2];
            ext_timer_clock_c_o <= any_clk_c & pa_pin_i[`SPS_PIN_A2];
            ext_timer_clock_b_o <= (phase_count_mode_i | any_clk_b) &
                                   pa_pin_i[`SPS_PIN_A1];
            ext_timer_clock_a_o <= (phase_count_mode_i | any_clk_a) &
                                   pa_pin_i[`SPS_PIN_A0];
        end
    end

endmodule

// decode of one timer control prescaler select field
module sps_psc_dec (
    input  wire [2:0] psc_i,
    output wire       clk_c_o,
    output wire       clk_b_o,
    output wire       clk_a_o
);

    assign clk_c_o = (psc_i == `SPS_PSC_CLK_C);
    assign clk_b_o = (psc_i == `SPS_PSC_CLK_B);
    // clock a select, bit 2 set and bit 1 clear
    assign clk_a_o = psc_i[2] & ~psc_i[1];

endmodule

// one port a pin: port data or pattern bit while output
module sps_pa_mux (
    input  wire dir_i,
    input  wire nde_i,
    input  wire data_i,
    input  wire pattern_i,
    output wire oe_o,
    output wire out_o
);

    // direction drives enable, enable bit picks pattern
    assign oe_o  = dir_i;
    assign out_o = nde_i ? pattern_i : data_i;

endmodule

// >>> sim/sps_port_sva.sv
// assertions on the shared i/o port pins and register bus
// assumes it is bound to the port and sees its ports by name
`include "sps_defines.vh"
module sps_port_sva (
    input logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o,
    input logic [17:0] wb_adr_i,
    input logic [3:0]  wb_sel_i,
    input logic [31:0] wb_dat_i, wb_dat_o,
    input logic        hw_standby_i, ch0_pwm_mode_i, phase_count_mode_i,
    input logic        timer_ch0_a_out_i, timer_ch0_a_pin_o,
    input logic        ext_timer_clock_a_o, ext_timer_clock_c_o,
    input logic        ext_timer_clock_b_o,
    input logic [2:0]  timer_ch0_io_control_i, pa_pin_i, pa_pin_o, pa_pin_oe_o,
    input logic [14:0] prescale_sel_i,
    input logic [7:0]  pb_pin_i, pb_pin_o, pb_pin_oe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic c6, c5, c4, own, tk;
    always_comb begin
        {c6, c5, c4} = 3'h0;
        for (int k = 0; k < 15; k += 3) begin
            c6 |= prescale_sel_i[k +: 3] == 3'h6;
            c5 |= prescale_sel_i[k +: 3] == 3'h5;
            c4 |= prescale_sel_i[k+1 +: 2] == 2'h2;
        end
    end
    assign own = ch0_pwm_mode_i | !timer_ch0_io_control_i[2] &
                 |timer_ch0_io_control_i[1:0];
    assign tk = wb_cyc_i & wb_stb_i & !wb_ack_o;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    own_drive_a: assert property (own |=> pa_pin_oe_o[2] &&
        pa_pin_o[2] == $past(timer_ch0_a_out_i)) else $error("a2 owner");
    cap_path_a: assert property (1'h1 |=> timer_ch0_a_pin_o ==
        ($past(pa_pin_i[2]) & $past(timer_ch0_io_control_i[2])))
        else $error("capture path");
    clk_c_a: assert property (1'h1 |=> ext_timer_clock_c_o ==
        ($past(c6) & $past(pa_pin_i[2]))) else $error("clock c");
    clk_b_a: assert property (1'h1 |=> ext_timer_clock_b_o ==
        ($past(pa_pin_i[1]) & ($past(c5) | $past(phase_count_mode_i))))
        else $error("clock b");
    clk_a_a: assert property (1'h1 |=> ext_timer_clock_a_o ==
        ($past(pa_pin_i[0]) & ($past(c4) | $past(phase_count_mode_i))))
        else $error("clock a");
    dir_write_a: assert property (wb_cyc_i && wb_stb_i &&
        wb_ack_o && wb_we_i && wb_sel_i[0] && !hw_standby_i &&
        wb_adr_i[17:2] == `SPS_PB_DIR_IDX |=>
        pb_pin_oe_o == $past(wb_dat_i[7:0])) else $error("direction write");
    dir_read_a: assert property (tk && !wb_we_i &&
        wb_adr_i[17:2] == `SPS_PB_DIR_IDX |=> wb_dat_o == 32'h0000_00FF)
        else $error("direction read");
    data_read_a: assert property (tk && !wb_we_i &&
        wb_adr_i[17:2] == `SPS_PB_DATA_IDX |=> wb_dat_o[7:0] ==
        ($past(pb_pin_o) & $past(pb_pin_oe_o) |
        $past(pb_pin_i) & ~$past(pb_pin_oe_o))) else $error("data read");
    hw_clear_a: assert property (hw_standby_i |=>
        pb_pin_o == 8'h00 && pb_pin_oe_o == 8'h00) else $error("standby");
    cover property (own);
    cover property (hw_standby_i);
    cover property (tk && !wb_we_i);
endmodule

// >>> sim/sps_pin_env.sv
// outside circuit on the port pins: a source behind a series resistor
// assumes the port's enable is high while it drives the pin
module sps_pin_env (
    input  logic [10:0] ext_i,
    input  logic [10:0] oe_i,
    input  logic [10:0] o_i,
    output logic [10:0] pin_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // a driving port wins over the outside source
    assign pin_o = oe_i & o_i | ~oe_i & ext_i;
endmodule

// >>> sim/tb.sv
// self-checking bench of the shared i/o port, reads checked off a queue
// assumes sps_port, sps_pin_env and sps_port_sva are compiled first
`include "sps_defines.vh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic        hw_standby_i, sw_standby_i, ch0_pwm_mode_i, upper_transfer_i;
    logic        phase_count_mode_i, timer_ch0_a_out_i, timer_ch0_a_pin_o;
    logic        ext_timer_clock_a_o, ext_timer_clock_b_o, ext_timer_clock_c_o;
    logic [3:0]  wb_sel_i;
    logic [17:0] wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, rq[$];
    logic [2:0]  timer_ch0_io_control_i, pattern_out_i, pa_ext;
    logic [2:0]  pa_pin_i, pa_pin_o, pa_pin_oe_o;
    logic [14:0] prescale_sel_i;
    logic [7:0]  upper_next_data_i, pb_pin_i, pb_pin_o, pb_pin_oe_o;
    logic [7:0]  pb_ext, d, v, e;
    int          n_fail, check_count, cyc, k;
    sps_port u_dut (.*);
    sps_pin_env u_env (.ext_i({pa_ext, pb_ext}),
        .oe_i({pa_pin_oe_o, pb_pin_oe_o}), .o_i({pa_pin_o, pb_pin_o}),
        .pin_o({pa_pin_i, pb_pin_i}));
    task automatic chk(input logic [31:0] s, input logic [31:0] x);
        check_count++;
        if (s !== x) begin
            n_fail++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, x);
        end
    endtask
    task automatic wb(input logic we, input logic [15:0] ix,
                      input logic [7:0] w);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, we};
        wb_adr_i <= {ix, 2'h0};
        wb_dat_i <= {24'h0, w};
        do @(posedge clk_i); while (wb_ack_o !== 1'h1);
        {wb_cyc_i, wb_stb_i} <= 2'h0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [15:0] ix, input logic [7:0] x);
        rq.push_back({24'h0, x});
        wb(1'h0, ix, 8'h00);
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        clk_i = 1'h0;
        forever #4 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (wb_ack_o === 1'h1 && wb_we_i === 1'h0)
            chk(wb_dat_o, rq.pop_front());
        if (cyc == 2000) begin
            n_fail++;
            close_out;
        end
    end
    initial begin
        {rst_i, wb_sel_i, wb_cyc_i, wb_stb_i, wb_we_i} = 8'hF8;
        {wb_adr_i, wb_dat_i, hw_standby_i, sw_standby_i} = '0;
        {ch0_pwm_mode_i, phase_count_mode_i, timer_ch0_a_out_i} = '0;
        {upper_transfer_i, timer_ch0_io_control_i, pattern_out_i} = '0;
        {prescale_sel_i, upper_next_data_i, pa_ext} = '0;
        pb_ext = 8'h5A;
        k = $urandom(92699);
        repeat (16) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        chk(32'({pb_pin_oe_o, pb_pin_o}), 32'h0);
        rd(`SPS_PB_DATA_IDX, 8'h5A);
        rd(16'h0100, 8'h00);
        for (k = 0; k < 8; k++) begin
            {d, v, e} = 24'($urandom);
            pb_ext <= e;
            wb(1'h1, `SPS_PB_DIR_IDX, d);
            wb(1'h1, `SPS_PB_DATA_IDX, v);
            chk(32'({pb_pin_oe_o, pb_pin_o}), 32'({d, v}));
            rd(`SPS_PB_DATA_IDX, v & d | e & ~d);
            rd(`SPS_PB_DIR_IDX, 8'hFF);
        end
        sw_standby_i <= 1'h1;
        repeat (4) @(posedge clk_i);
        chk(32'({pb_pin_oe_o, pb_pin_o}), 32'({d, v}));
        sw_standby_i <= 1'h0;
        wb(1'h1, `SPS_PB_DIR_IDX, 8'hFF);
        wb(1'h1, `SPS_NDE_HI_IDX, 8'hF0);
        wb(1'h1, `SPS_PB_DATA_IDX, 8'hFF);
        chk(32'(pb_pin_o), 32'(v | 8'h0F));
        upper_next_data_i <= e;
        upper_transfer_i <= 1'h1;
        @(posedge clk_i);
        upper_transfer_i <= 1'h0;
        rd(`SPS_PB_DATA_IDX, e | 8'h0F);
        hw_standby_i <= 1'h1;
        @(posedge clk_i);
        hw_standby_i <= 1'h0;
        @(posedge clk_i);
        chk(32'({pb_pin_oe_o, pb_pin_o}), 32'h0);
        pattern_out_i <= v[2:0];
        wb(1'h1, `SPS_PA_DIR_IDX, 8'h07);
        wb(1'h1, `SPS_PA_DATA_IDX, 8'h05);
        @(posedge clk_i);
        chk(32'({pa_pin_oe_o, pa_pin_o}), 32'h3D);
        wb(1'h1, `SPS_NDE_LO_IDX, 8'h07);
        @(posedge clk_i);
        chk(32'(pa_pin_o), 32'(v[2:0]));
        wb(1'h1, `SPS_PA_DIR_IDX, 8'h00);
        for (k = 0; k < 40; k++) begin
            {phase_count_mode_i, timer_ch0_io_control_i, ch0_pwm_mode_i} <= 5'(k);
            prescale_sel_i <= 15'($urandom_range(7)) << (3 * (k % 5));
            {pa_ext, timer_ch0_a_out_i} <= 4'($urandom);
            repeat (3) @(posedge clk_i);
            chk(32'(pa_pin_oe_o[2]),
                32'(k[0] | !k[3] & |k[2:1]));
        end
        close_out;
    end
endmodule
bind sps_port sps_port_sva u_chk (.*);
